// >>> nvss_defines.vh
// Timing constants for the store/recall sequencer.
// Assumes a 25 MHz reference clock; counts are derived from times in their own unit.
`ifndef NVSS_DEFINES_VH
`define NVSS_DEFINES_VH
`define NVSS_CLK_MHZ 25
// Times as given (longest times round down)
`define NVSS_RECALL_LV_MS 40
`define NVSS_RECALL_MS 20
`define NVSS_STORE_MS 8
`define NVSS_SRECALL_US 600
`define NVSS_SOFT_SEQ_US 500
`define NVSS_SLEEP_MS 8
`define NVSS_STANDBY_US 100
`define NVSS_PIN_DRIVE_NS 500
`define NVSS_ACCESS_US 5
`define NVSS_WRITE_GRACE_NS 25
// Cycle counts at 25 MHz, sized to the 20-bit interval timers
`define NVSS_RECALL_LV_CYC 20'hf4240
`define NVSS_RECALL_CYC 20'h7a120
`define NVSS_STORE_CYC 20'h30d40
`define NVSS_SRECALL_CYC 20'h03a98
`define NVSS_SOFT_SEQ_CYC 20'h030d4
`define NVSS_SLEEP_CYC 20'h30d40
`define NVSS_STANDBY_CYC 20'h009c4
`define NVSS_PIN_DRIVE_CYC 20'h0000c
`define NVSS_ACCESS_CYC 20'h0007d
// 25 ns is under one 40 ns cycle, so it floors to the one-cycle minimum
`define NVSS_WRITE_GRACE_CYC 20'h00001
`endif

// >>> nvss_timer.v
// Down-counting one-shot timer used for every sequencer interval.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module nvss_timer #(
    parameter W = 20
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Control
    input wire load,
    input wire [W-1:0] count,
    // Status
    output reg done
);
    reg [W-1:0] remain;
    reg running;

    // Load wins over a running count; done pulses when the count reaches its end
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            remain <= {W{1'b0}};
            running <= 1'b0;
            done <= 1'b0;
        end
        else if (load)
        begin
            remain <= count;
            running <= 1'b1;
            done <= 1'b0;
        end
        else if (running && remain <= {{(W-1){1'b0}}, 1'b1})
        begin
            running <= 1'b0;
            done <= 1'b1;
        end
        else
        begin
            remain <= remain - {{(W-1){1'b0}}, 1'b1};
            done <= 1'b0;
        end
    end
endmodule // nvss_timer
`default_nettype wire

// >>> nvss_sequencer.v
// Store/recall sequencer of a serial nonvolatile SRAM.
// Assumes supply status and commands arrive synchronous to REF_CLK, already decoded.
`timescale 1ns/1ps
`default_nettype none
`include "nvss_defines.vh"
// Function
// (RULE_01) Power-up recall ends within 40 ms (low-voltage) or 20 ms after supply rises.
// (RULE_02) Power-loss save and pin store are skipped if no SRAM write since the last cycle.
// (RULE_03) Accesses are ignored during store or recall and while supply is low.
// (RULE_04) SRAM stays enabled one grace cycle after a store, recall or save-enable change starts.
// (RULE_05) Soft commands are acted on within 500 us of receipt.
// (RULE_06) Serial I/O is blocked until a store or recall completes.
// (RULE_07) Sleep is entered no later than 8 ms after the sleep command.
// (RULE_08) The host waits the wake time after waking the device before access.
// (RULE_09) Standby is entered within 100 us of chip select going high.
// (RULE_10) An outside store request holds the store pin low at least 15 ns.
// (RULE_11) SRAM is disabled the whole time the store pin is held low from outside; the code drops SRAM_ENABLE up to four cycles after the pin falls.
// (RULE_12) After a store the store pin is driven high at most 500 ns, then released.
// (RULE_13) Access returns no later than 5 us after the store pin goes high.
// (RULE_14) Store ends within 8 ms, software recall within 600 us, busy held throughout.
// (RULE_15) Without a store pin, power-loss save and pin store are absent.
module nvss_sequencer #(
    parameter HAS_PIN = 1,
    parameter HAS_SAVE = 1,
    parameter LOW_VOLT = 0,
    parameter [19:0] RECALL_LV_CYC = `NVSS_RECALL_LV_CYC,
    parameter [19:0] RECALL_CYC = `NVSS_RECALL_CYC,
    parameter [19:0] STORE_CYC = `NVSS_STORE_CYC,
    parameter [19:0] SLEEP_CYC = `NVSS_SLEEP_CYC,
    parameter [19:0] SRECALL_CYC = `NVSS_SRECALL_CYC,
    parameter [19:0] SOFT_SEQ_CYC = `NVSS_SOFT_SEQ_CYC,
    parameter [19:0] STANDBY_CYC = `NVSS_STANDBY_CYC,
    parameter [19:0] ACCESS_CYC = `NVSS_ACCESS_CYC
) (
    // Clock and reset
    input wire REF_CLK,
    input wire RST_N,
    // Supply and chip select
    input wire SUPPLY_OK,
    input wire CS_N,
    // Decoded soft commands and the SRAM write strobe, one-cycle pulses
    input wire CMD_STORE,
    input wire CMD_RECALL,
    input wire CMD_SAVE_EN,
    input wire CMD_SAVE_DIS,
    input wire CMD_SLEEP,
    input wire SRAM_WRITE,
    // Open-drain store/busy pin
    input wire STORE_BUSY_PIN_IN,
    output reg STORE_BUSY_PIN_OUT,
    output reg STORE_BUSY_PIN_OE,
    // Status
    output reg SRAM_ENABLE,
    output reg ACCESS_INHIBIT_WINDOW,
    output reg BUSY,
    output reg SLEEPING,
    output reg STANDBY,
    output reg SAVE_ENABLED
);
    localparam [3:0] ST_OFF = 4'h0, ST_PRECALL = 4'h1, ST_IDLE = 4'h2, ST_GRACE = 4'h3;
    localparam [3:0] ST_STORE = 4'h4, ST_RECALL = 4'h5, ST_DRIVE = 4'h6, ST_SETTLE = 4'h7;
    localparam [3:0] ST_SLEEPING = 4'h8, ST_SLEEP = 4'h9, ST_PINLOW = 4'ha, ST_SOFT = 4'hb;
    localparam [1:0] OP_STORE = 2'h0, OP_RECALL = 2'h1, OP_SAVE = 2'h2;
    localparam [19:0] DRIVE_CYC = `NVSS_PIN_DRIVE_CYC;
    localparam [19:0] GRACE_CYC = `NVSS_WRITE_GRACE_CYC;

    reg [3:0] state;
    reg [1:0] op;
    reg dirty;
    reg save_arg;
    reg tload;
    reg [19:0] tcount;
    wire tdone;
    reg sb_load;
    wire sb_done;
    wire pin_low = (HAS_PIN != 0) && !STORE_BUSY_PIN_IN && !STORE_BUSY_PIN_OE;
    wire skip = !dirty;
    wire save_ok = (HAS_SAVE != 0) && (HAS_PIN != 0) && SAVE_ENABLED;

    // Registered hand-offs eat a few cycles of each interval, so loads are shortened
    function [19:0] trim_cyc;
        input [19:0] n;
        input [19:0] k;
        trim_cyc = (n > k) ? n - k : 20'h00001;
    endfunction
    wire [19:0] recall_len = trim_cyc((LOW_VOLT != 0) ? RECALL_LV_CYC : RECALL_CYC, 20'h00002);

    // Interval timer for the main sequence
    nvss_timer #(.W(20)) u_timer (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .load(tload),
        .count(tcount),
        .done(tdone)
    );
    // Separate standby timer so chip select idle never disturbs an operation
    nvss_timer #(.W(20)) u_standby (
        .clk(REF_CLK),
        .rst_n(RST_N),
        .load(sb_load),
        .count(trim_cyc(STANDBY_CYC, 20'h00002)),
        .done(sb_done)
    );

    // Timer loads, decided from the state and its triggers
    always @*
    begin
        tload = 1'b0;
        tcount = GRACE_CYC;
        case (state)
            ST_OFF:
                if (SUPPLY_OK)
                begin
                    tload = 1'b1;
                    tcount = recall_len; // RULE_01
                end
            ST_IDLE:
                if (!SUPPLY_OK || pin_low
                    || CMD_STORE || CMD_RECALL || CMD_SAVE_EN || CMD_SAVE_DIS)
                begin
                    tload = 1'b1;
                    tcount = GRACE_CYC; // RULE_04
                end
                else if (CMD_SLEEP)
                begin
                    tload = 1'b1;
                    tcount = trim_cyc(SLEEP_CYC, 20'h00002); // RULE_07
                end
            ST_GRACE:
                if (tdone)
                begin
                    tload = 1'b1;
                    tcount = (op == OP_STORE) ? trim_cyc(STORE_CYC, 20'h00003) :
                             (op == OP_RECALL) ? trim_cyc(SRECALL_CYC, 20'h00003) :
                             trim_cyc(SOFT_SEQ_CYC, 20'h00003); // RULE_14
                end
            ST_STORE:
                if (tdone)
                begin
                    tload = 1'b1;
                    tcount = trim_cyc(DRIVE_CYC, 20'h00001); // RULE_12
                end
            ST_DRIVE, ST_RECALL, ST_PINLOW:
                if ((state == ST_PINLOW) ? STORE_BUSY_PIN_IN : tdone)
                begin
                    tload = 1'b1;
                    tcount = trim_cyc(ACCESS_CYC, 20'h00003); // RULE_13
                end
            ST_SLEEPING:
                if (!CS_N)
                begin
                    tload = 1'b1;
                    tcount = recall_len;
                end
            default:
            begin
                tload = 1'b0;
                tcount = GRACE_CYC;
            end
        endcase
    end

    // Main sequence
    always @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            state <= ST_OFF;
            op <= OP_STORE;
            dirty <= 1'b0;
            save_arg <= 1'b0;
            SAVE_ENABLED <= 1'b1;
        end
        else if (!SUPPLY_OK && state != ST_IDLE && state != ST_GRACE && state != ST_STORE)
        begin
            state <= ST_OFF; // RULE_03
        end
        else
        begin
            // A write landing with the store start still marks the array dirty
            if (SRAM_WRITE && SRAM_ENABLE)
                dirty <= 1'b1;
            case (state)
                ST_OFF:
                    if (SUPPLY_OK)
                        state <= ST_PRECALL;
                ST_PRECALL:
                    if (tdone)
                    begin
                        state <= ST_IDLE;
                        dirty <= 1'b0;
                    end
                ST_IDLE:
                    if (!SUPPLY_OK || pin_low)
                    begin
                        op <= OP_STORE;
                        // A power-loss save needs the pin, the feature and the enable
                        state <= skip ? (pin_low ? ST_PINLOW : ST_OFF) : // RULE_02
                                 (SUPPLY_OK || save_ok) ? ST_GRACE : ST_OFF; // RULE_15
                    end
                    else if (CMD_STORE || CMD_RECALL)
                    begin
                        op <= CMD_STORE ? OP_STORE : OP_RECALL;
                        state <= ST_GRACE; // RULE_05
                    end
                    else if (CMD_SAVE_EN || CMD_SAVE_DIS)
                    begin
                        op <= OP_SAVE;
                        save_arg <= CMD_SAVE_EN;
                        state <= ST_GRACE;
                    end
                    else if (CMD_SLEEP)
                        state <= ST_SLEEP;
                ST_GRACE:
                    if (tdone)
                        state <= (op == OP_STORE) ? ST_STORE :
                                 (op == OP_RECALL) ? ST_RECALL : ST_SOFT;
                ST_STORE:
                    if (tdone)
                    begin
                        dirty <= 1'b0;
                        state <= ST_DRIVE;
                    end
                ST_RECALL:
                    if (tdone)
                    begin
                        dirty <= 1'b0;
                        state <= ST_SETTLE;
                    end
                ST_SOFT:
                    if (tdone)
                    begin
                        SAVE_ENABLED <= save_arg;
                        state <= ST_IDLE;
                    end
                ST_DRIVE:
                    if (tdone)
                        state <= (pin_low || !STORE_BUSY_PIN_IN) ? ST_PINLOW : ST_SETTLE;
                ST_PINLOW:
                    if (STORE_BUSY_PIN_IN)
                        state <= ST_SETTLE; // RULE_11
                ST_SETTLE:
                    if (tdone)
                        state <= ST_IDLE;
                ST_SLEEP:
                    if (tdone)
                        state <= ST_SLEEPING;
                ST_SLEEPING:
                    if (!CS_N)
                        state <= ST_PRECALL;
                default:
                    state <= ST_OFF;
            endcase
        end
    end

    // Standby after chip select rises, restarted by any select low
    always @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            STANDBY <= 1'b0;
            sb_load <= 1'b0;
        end
        else
        begin
            sb_load <= !CS_N;
            if (!CS_N)
                STANDBY <= 1'b0;
            else if (sb_done)
                STANDBY <= 1'b1; // RULE_09
        end
    end

    // Registered outputs
    always @(posedge REF_CLK)
    begin
        if (!RST_N)
        begin
            SRAM_ENABLE <= 1'b0;
            ACCESS_INHIBIT_WINDOW <= 1'b1;
            BUSY <= 1'b1;
            SLEEPING <= 1'b0;
            STORE_BUSY_PIN_OUT <= 1'b0;
            STORE_BUSY_PIN_OE <= 1'b0;
        end
        else
        begin
            SRAM_ENABLE <= SUPPLY_OK && (state == ST_IDLE || state == ST_GRACE); // RULE_04
            ACCESS_INHIBIT_WINDOW <= !(SUPPLY_OK && state == ST_IDLE); // RULE_06
            BUSY <= state != ST_IDLE; // RULE_14
            SLEEPING <= state == ST_SLEEPING;
            // Drive low through the store, high briefly after, then release
            STORE_BUSY_PIN_OUT <= (state == ST_STORE && !tdone) ? 1'b0 : 1'b1; // RULE_12
            STORE_BUSY_PIN_OE <= (HAS_PIN != 0)
                && (state == ST_STORE || (state == ST_DRIVE && !tdone));
        end
    end
endmodule // nvss_sequencer
`default_nettype wire

// >>> nvss_host_model.sv
// Far-side model: outside store requester and the pull-up on the store/busy wire.
// Assumes requests arrive as one-cycle pulses on the reference clock.
`timescale 1ns/1ps
`default_nettype none
module nvss_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request from the bench
    input wire logic req,
    input wire logic [7:0] hold,
    // Device side of the wire
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_in
);
    logic [7:0] cnt;
    // Low for whole cycles, so never shorter than 40 ns
    always @(posedge clk)
        if (!rst_n) cnt <= 8'h00;
        else if (req) cnt <= hold;
        else if (cnt != 8'h00) cnt <= cnt - 8'h01;
    // Pull-up wins only while nobody drives low
    assign pin_in = !((pin_oe && !pin_out) || cnt != 8'h00);
endmodule // nvss_host_model
`default_nettype wire

// >>> nvss_sequencer_properties.sv
// Timing checker for the store/recall sequencer, bound to its top ports.
// Assumes the short timing parameters that the bench hands down.
`timescale 1ns/1ps
`default_nettype none
module nvss_sequencer_properties #(
    parameter [19:0] STORE_CYC = 20'h0003c,
    parameter [19:0] SRECALL_CYC = 20'h0001e,
    parameter [19:0] STANDBY_CYC = 20'h00014,
    parameter [19:0] ACCESS_CYC = 20'h00014
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RST_N,
    // Inputs
    input wire logic SUPPLY_OK,
    input wire logic CS_N,
    input wire logic CMD_STORE,
    input wire logic CMD_RECALL,
    input wire logic CMD_SAVE_EN,
    input wire logic CMD_SAVE_DIS,
    input wire logic CMD_SLEEP,
    input wire logic SRAM_WRITE,
    input wire logic STORE_BUSY_PIN_IN,
    // Outputs
    input wire logic STORE_BUSY_PIN_OUT,
    input wire logic STORE_BUSY_PIN_OE,
    input wire logic SRAM_ENABLE,
    input wire logic ACCESS_INHIBIT_WINDOW,
    input wire logic BUSY,
    input wire logic SLEEPING,
    input wire logic STANDBY,
    input wire logic SAVE_ENABLED
);
    // Store low phase plus the short high drive
    localparam int STORE_MAX = STORE_CYC + 16;
    localparam int RECALL_MAX = SRECALL_CYC + ACCESS_CYC + 8;
    localparam int SB_LIM = STANDBY_CYC + 4;
    logic [19:0] sb_cnt;
    wire logic take = (CMD_STORE || CMD_RECALL) && !BUSY && SUPPLY_OK;
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    // Idle deselected cycles; saturates so it never wraps
    always @(posedge REF_CLK)
        if (!RST_N || !CS_N || BUSY || !SUPPLY_OK) sb_cnt <= 20'h00000;
        else if (sb_cnt != 20'hfffff) sb_cnt <= sb_cnt + 20'h00001;
    a_inhibit_low_supply: assert property ($fell(SUPPLY_OK) |-> ##[1:3] ACCESS_INHIBIT_WINDOW)
        else $error("access not inhibited after supply drop");
    a_store_drive_lock: assert property (STORE_BUSY_PIN_OE && !STORE_BUSY_PIN_OUT |->
        ACCESS_INHIBIT_WINDOW && !SRAM_ENABLE && BUSY) else $error("access open during store");
    a_drive_high_short: assert property ($rose(STORE_BUSY_PIN_OUT) && STORE_BUSY_PIN_OE |->
        ##[1:12] !STORE_BUSY_PIN_OE) else $error("pin driven high too long");
    a_store_ends: assert property ($rose(STORE_BUSY_PIN_OE) |-> ##[1:STORE_MAX] !STORE_BUSY_PIN_OE)
        else $error("store overran its bound");
    a_pin_held_off: assert property ((!STORE_BUSY_PIN_IN && !STORE_BUSY_PIN_OE)[*5] |-> !SRAM_ENABLE)
        else $error("sram enabled while pin held low");
    a_sram_grace: assert property (take |-> ##1 SRAM_ENABLE ##[1:3] !SRAM_ENABLE)
        else $error("sram grace window wrong");
    a_cmd_busy: assert property (take |-> ##2 BUSY)
        else $error("busy late after command");
    a_recall_ends: assert property (CMD_RECALL && !CMD_STORE && !BUSY && SUPPLY_OK |->
        ##2 BUSY ##[1:RECALL_MAX] !BUSY) else $error("recall overran its bound");
    a_standby_entry: assert property (sb_cnt == SB_LIM[19:0] |-> STANDBY)
        else $error("standby not entered in time");
    c_store_done: cover property ($fell(STORE_BUSY_PIN_OE));
    c_standby: cover property ($rose(STANDBY));
    c_sleep: cover property ($rose(SLEEPING));
endmodule // nvss_sequencer_properties
bind nvss_sequencer nvss_sequencer_properties #(.STORE_CYC(STORE_CYC), .SRECALL_CYC(SRECALL_CYC),
    .STANDBY_CYC(STANDBY_CYC), .ACCESS_CYC(ACCESS_CYC)) u_nvss_props (.REF_CLK(REF_CLK),
    .RST_N(RST_N), .SUPPLY_OK(SUPPLY_OK), .CS_N(CS_N), .CMD_STORE(CMD_STORE),
    .CMD_RECALL(CMD_RECALL), .CMD_SAVE_EN(CMD_SAVE_EN), .CMD_SAVE_DIS(CMD_SAVE_DIS),
    .CMD_SLEEP(CMD_SLEEP), .SRAM_WRITE(SRAM_WRITE), .STORE_BUSY_PIN_IN(STORE_BUSY_PIN_IN),
    .STORE_BUSY_PIN_OUT(STORE_BUSY_PIN_OUT), .STORE_BUSY_PIN_OE(STORE_BUSY_PIN_OE),
    .SRAM_ENABLE(SRAM_ENABLE), .ACCESS_INHIBIT_WINDOW(ACCESS_INHIBIT_WINDOW), .BUSY(BUSY),
    .SLEEPING(SLEEPING), .STANDBY(STANDBY), .SAVE_ENABLED(SAVE_ENABLED));
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the store/recall sequencer with short timing parameters.
// Assumes the host model owns the pull-up; the checker is bound separately.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam [19:0] RC = 20'h00028, ST = 20'h0003c, SL = 20'h0001e, SR = 20'h0001e;
    localparam [19:0] SS = 20'h00014, SB = 20'h00014, AC = 20'h00014;
    logic clk, rst_n, supply_ok, cs_n, sram_write, req, oe_seen, oe_clr;
    logic [4:0] cmd;
    logic [7:0] hold, hl;
    wire logic pin_in, pin_out, pin_oe, sram_en, inhibit, busy, sleeping, standby, save_en;
    int n_errors = 0, n_tests = 0, seed = 32'h55cc, c, i;
    nvss_sequencer #(.RECALL_LV_CYC(20'h00032), .RECALL_CYC(RC), .STORE_CYC(ST),
        .SLEEP_CYC(SL), .SRECALL_CYC(SR), .SOFT_SEQ_CYC(SS), .STANDBY_CYC(SB),
        .ACCESS_CYC(AC)) u_nvss_sequencer (.REF_CLK(clk), .RST_N(rst_n),
        .SUPPLY_OK(supply_ok), .CS_N(cs_n), .CMD_STORE(cmd[0]), .CMD_RECALL(cmd[1]),
        .CMD_SAVE_EN(cmd[2]), .CMD_SAVE_DIS(cmd[3]), .CMD_SLEEP(cmd[4]),
        .SRAM_WRITE(sram_write), .STORE_BUSY_PIN_IN(pin_in), .STORE_BUSY_PIN_OUT(pin_out),
        .STORE_BUSY_PIN_OE(pin_oe), .SRAM_ENABLE(sram_en), .ACCESS_INHIBIT_WINDOW(inhibit),
        .BUSY(busy), .SLEEPING(sleeping), .STANDBY(standby), .SAVE_ENABLED(save_en));
    nvss_host_model u_nvss_host_model (.clk(clk), .rst_n(rst_n), .req(req), .hold(hold),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
    // 25 MHz reference clock
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Remembers any drive of the store/busy pin until the bench clears it
    always @(posedge clk)
        if (!rst_n || oe_clr) oe_seen <= 1'b0;
        else if (pin_oe === 1'b1) oe_seen <= 1'b1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("tests=%0d errors=%0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Bounded wait for idle; running out ends the run
    task automatic wait_idle(input int lim);
        c = 0;
        while (busy !== 1'b0 && c < lim)
        begin
            @(negedge clk);
            c++;
        end
        if (busy !== 1'b0)
        begin
            n_errors++;
            summarize;
        end
    endtask
    // Longest accepted busy time of an operation, from the package-free bench constants
    function automatic int op_limit(input int cyc);
        return cyc + AC + 24;
    endfunction
    task automatic clear_oe;
        @(posedge clk);
        oe_clr <= 1'b1;
        @(posedge clk);
        oe_clr <= 1'b0;
    endtask
    // Busy rises two edges after the take, so wait it out before polling for idle
    task automatic issue(input int k);
        @(posedge clk);
        cmd <= 5'h01 << k;
        @(posedge clk);
        cmd <= 5'h00;
        repeat (2) @(negedge clk);
    endtask
    task automatic pulse_write;
        @(posedge clk);
        sram_write <= 1'b1;
        @(posedge clk);
        sram_write <= 1'b0;
    endtask
    task automatic pin_req(input logic [7:0] h);
        @(posedge clk);
        req <= 1'b1;
        hold <= h;
        @(posedge clk);
        req <= 1'b0;
    endtask
    // Main sequence; samples are taken on falling edges where outputs are settled
    initial
    begin
        rst_n = 1'b0; supply_ok = 1'b1; cs_n = 1'b0; cmd = 5'h00;
        sram_write = 1'b0; req = 1'b0; hold = 8'h01; oe_clr = 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        wait_idle(RC + 40);
        chk(c <= RC + 8, 1);
        chk(inhibit, 0);
        $display("powerup done");
        for (i = 0; i < 3; i++)
        begin
            repeat (1 + ($random(seed) & 3)) pulse_write;
            clear_oe;
            issue(0);
            repeat (6) @(negedge clk);
            issue(1);
            wait_idle(ST + AC + 60);
            chk(oe_seen, 1);
            chk(c <= op_limit(ST), 1);
            repeat (4) @(negedge clk);
            chk(busy, 0);
        end
        issue(1);
        wait_idle(SR + AC + 40);
        chk(c <= op_limit(SR), 1);
        chk(sram_en, 1);
        $display("soft store recall done");
        clear_oe;
        hl = 8'h0a + 8'($random(seed) & 7);
        pin_req(hl);
        repeat (5) @(negedge clk);
        chk(sram_en, 0);
        repeat (hl + AC + 8) @(negedge clk);
        chk(oe_seen, 0);
        chk(inhibit, 0);
        pulse_write;
        pin_req(8'h02);
        repeat (8) @(negedge clk);
        chk(oe_seen, 1);
        wait_idle(ST + AC + 60);
        $display("pin store done");
        for (i = 3; i >= 2; i--)
        begin
            issue(i);
            wait_idle(SS + AC + 40);
            chk(save_en, i == 2);
        end
        @(posedge clk);
        cs_n <= 1'b1;
        repeat (SB + 6) @(negedge clk);
        chk(standby, 1);
        issue(4);
        repeat (SL + 6) @(negedge clk);
        chk(sleeping, 1);
        @(posedge clk);
        cs_n <= 1'b0;
        wait_idle(RC + 40);
        chk(c <= RC + 8, 1);
        chk(standby, 0);
        $display("standby sleep done");
        for (i = 0; i < 2; i++)
        begin
            if (i == 0) pulse_write;
            clear_oe;
            @(posedge clk);
            supply_ok <= 1'b0;
            repeat (8) @(negedge clk);
            chk(oe_seen, i == 0);
            chk(inhibit, 1);
            repeat (ST + 24) @(negedge clk);
            @(posedge clk);
            supply_ok <= 1'b1;
            wait_idle(RC + 60);
            chk(inhibit, 0);
        end
        $display("power loss done");
        summarize;
    end
endmodule // tb_top
`default_nettype wire
